// ===== rtl/spf_cfg.svh
`ifndef SPF_CFG_SVH
`define SPF_CFG_SVH
// Register offset on the plain register port
`define SPF_CSR_ADDR       4'h0
`define SPF_CSR_RESET      8'h00
// Control and status bit positions
`define SPF_BIT_RDY_IE     7
`define SPF_BIT_BUSY       6
`define SPF_BIT_SIG        5
`define SPF_BIT_REEN       4
`define SPF_BIT_LOCK       3
`define SPF_BIT_PWR        2
`define SPF_BIT_PERS       1
`define SPF_BIT_EN         0
// Command patterns in the low six bits
`define SPF_CMD_SIG        6'h21
`define SPF_CMD_REEN       6'h11
`define SPF_CMD_LOCK       6'h09
`define SPF_CMD_PWR        6'h05
`define SPF_CMD_PERS       6'h03
`define SPF_CMD_FILL       6'h01
// Store and load windows in clock cycles
`define SPF_STORE_WIN      3'h4
`define SPF_LOAD_WIN       3'h3
// Application reset address
`define SPF_APP_RESET      16'h0000
// Z pointer layout: word bits [6:1], page bits [15:7]
`define SPF_WORD_MSB       6
`define SPF_WORD_LSB       1
`define SPF_PAGE_LSB       7
`define SPF_PAGE_W         9
`define SPF_WORD_W         6
`define SPF_BUF_DEPTH      64
// Flash program/erase time, nanoseconds
`define SPF_PROG_NS        4000
`define SPF_PROG_CYC       ((`SPF_PROG_NS + 9) / 10)
`endif

// ===== rtl/spf_pkg.sv
package spf_pkg;
  typedef enum logic [2:0] {SPF_IDLE, SPF_ARMED, SPF_PROG} spf_state_e;
  typedef enum logic [2:0] {SPF_OP_NONE, SPF_OP_SIG, SPF_OP_REEN, SPF_OP_LOCK,
                            SPF_OP_PWR, SPF_OP_PERS, SPF_OP_FILL} spf_op_e;
  typedef struct packed {
    logic        store;
    logic        load;
    logic [15:0] zptr;
    logic [15:0] rdata;
  } spf_instr_s;
  typedef struct packed {
    logic        valid;
    logic [7:0]  data;
  } spf_lret_s;
endpackage

// ===== rtl/spf_ctrl.sv
`timescale 1ns/1ps
`include "spf_cfg.svh"
// Behaviour
// - Boot fuse selects application or boot reset
// - Fuses never writable from software
// - Ready interrupt while enable bit clear
// - Busy flag set on section programming
// - Busy clears on re-enable or fill
// - Signature load returns signature byte
// - Signature store has no effect
// - Re-enable store unblocks busy section
// - No re-enable during erase or write
// - Re-enable aborts fill, discards buffer
// - Lock store programs lock bits from R0
// - Lock load returns lock or fuse
// - Page write from buffer, halts core for pages at or above RWW_PAGE_LIMIT
// - Page erase at latched page
// - Plain store fills buffer word
// - Enable opens four-cycle store window
// - Only six command patterns accepted
// - Z split word/page, latched at start
// - Signature loads byte addressed via bit0, lock loads select via bits 1:0
// - Halt core when protected region programmed
// - Buffer clears on write, re-enable, reset
module spf_ctrl
  import spf_pkg::*;
#(
  parameter logic [15:0] BOOT_RESET_ADDR = 16'hF000,
  parameter logic [8:0]  RWW_PAGE_LIMIT  = 9'h100,
  parameter logic [7:0]  SIG_BYTE0       = 8'h5A,  // Arbitrary value
  parameter logic [7:0]  SIG_BYTE1       = 8'hA5,  // Arbitrary value
  parameter int          PROG_CYC        = `SPF_PROG_CYC
)(
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  // Register port
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic [7:0]       REG_RDATA,
  // Core instruction side
  input  wire spf_instr_s  INSTR,
  input  wire logic        GLOBAL_IE,
  output spf_lret_s        LOAD_RET,
  output logic             READY_IRQ,
  output logic             CORE_HALT,
  output logic             SECTION_BLOCKED,
  // Fuses and lock bits
  input  wire logic        BOOT_RESET_FUSE,
  input  wire logic [7:0]  FUSE_LOW,
  input  wire logic [7:0]  FUSE_HIGH,
  output logic [15:0]      RESET_VECTOR,
  output logic [7:0]       LOCK_BITS
);

  typedef struct packed {
    spf_state_e  state;
    spf_op_e     op;
    logic [2:0]  win;
    logic [31:0] prog_cnt;
    logic        ie;
    logic        busy;
    logic        sig;
    logic        reen;
    logic        lock;
    logic        pwr;
    logic        pers;
    logic        en;
    logic [8:0]  page;
    logic        tgt_rww;
    logic [7:0]  lockb;
    logic [`SPF_BUF_DEPTH-1:0] buf_vld;
    logic [7:0]  rdata;
    spf_lret_s   lret;
    logic        irq;
    logic        halt;
    logic        fuse_q1;
    logic        fuse_q2;
    logic [15:0] rvec;
    logic        rvec_set;
    logic [1:0]  settle;
  } spf_regs_s;

  spf_regs_s r;
  spf_regs_s next_r;
  logic [15:0] buf_mem [`SPF_BUF_DEPTH];
  logic [5:0]  cmd;
  logic        csr_wr;
  logic [7:0]  csr_val;
  logic [`SPF_WORD_W-1:0] zword;
  logic        page_busy_done;

  assign cmd = REG_WDATA[5:0];
  assign csr_wr = REG_WR && (REG_ADDR == `SPF_CSR_ADDR);
  assign zword = INSTR.zptr[`SPF_WORD_MSB:`SPF_WORD_LSB];
  assign csr_val = {r.ie, r.busy, r.sig, r.reen, r.lock, r.pwr, r.pers, r.en};
  assign page_busy_done = (r.state == SPF_PROG) && (r.prog_cnt == 32'h0000_0001);

  always_comb
  begin
    next_r = r;
    next_r.lret.valid = 1'b0;
    next_r.rdata = (REG_RD && REG_ADDR == `SPF_CSR_ADDR) ? csr_val : 8'h00;
    // Fuse pin crosses from outside, so two stages first
    next_r.fuse_q1 = BOOT_RESET_FUSE;
    next_r.fuse_q2 = r.fuse_q1;
    // Vector waits two edges so the synchroniser holds the true pin level
    if (!r.rvec_set && r.settle == 2'h2)
    begin
      next_r.rvec_set = 1'b1;
      next_r.rvec = r.fuse_q2 ? `SPF_APP_RESET : BOOT_RESET_ADDR;
    end
    else if (!r.rvec_set)
      next_r.settle = r.settle + 2'h1;
    // Fuse inputs are read only; no write path exists
    unique case (r.state)
      SPF_IDLE:
      begin
        if (csr_wr)
        begin
          next_r.ie = REG_WDATA[`SPF_BIT_RDY_IE];
          next_r.op = SPF_OP_NONE;
          unique case (cmd)
            `SPF_CMD_SIG:  next_r.op = SPF_OP_SIG;
            `SPF_CMD_REEN: next_r.op = SPF_OP_REEN;
            `SPF_CMD_LOCK: next_r.op = SPF_OP_LOCK;
            `SPF_CMD_PWR:  next_r.op = SPF_OP_PWR;
            `SPF_CMD_PERS: next_r.op = SPF_OP_PERS;
            `SPF_CMD_FILL: next_r.op = SPF_OP_FILL;
            default:       next_r.op = SPF_OP_NONE;
          endcase
          if (next_r.op != SPF_OP_NONE)
          begin
            {next_r.sig, next_r.reen, next_r.lock, next_r.pwr, next_r.pers, next_r.en} = cmd;
            next_r.win = `SPF_STORE_WIN;
            next_r.state = SPF_ARMED;
          end
        end
      end
      SPF_ARMED:
      begin
        if (csr_wr)
          next_r.ie = REG_WDATA[`SPF_BIT_RDY_IE];
        if (INSTR.store)
        begin
          next_r.state = SPF_IDLE;
          {next_r.sig, next_r.reen, next_r.lock, next_r.pwr, next_r.pers, next_r.en} = 6'h00;
          unique case (r.op)
            SPF_OP_SIG: ;
            SPF_OP_REEN:
            begin
              next_r.busy = 1'b0;
              next_r.buf_vld = '0;
            end
            SPF_OP_LOCK:
              next_r.lockb = r.lockb & (INSTR.rdata[7:0] | 8'hC3);
            SPF_OP_FILL:
            begin
              next_r.busy = 1'b0;
              next_r.buf_vld[zword] = 1'b1;
            end
            default:
            begin
              // Erase or write: latch page, keep enable high
              next_r.page = INSTR.zptr[15:`SPF_PAGE_LSB];
              next_r.tgt_rww = INSTR.zptr[15:`SPF_PAGE_LSB] < RWW_PAGE_LIMIT;
              next_r.busy = r.busy | next_r.tgt_rww;
              next_r.halt = !next_r.tgt_rww;
              next_r.pwr = (r.op == SPF_OP_PWR);
              next_r.pers = (r.op == SPF_OP_PERS);
              next_r.en = 1'b1;
              next_r.prog_cnt = PROG_CYC;
              next_r.state = SPF_PROG;
            end
          endcase
        end
        else if (INSTR.load && r.win > (`SPF_STORE_WIN - `SPF_LOAD_WIN)
                 && (r.op == SPF_OP_SIG || r.op == SPF_OP_LOCK))
        begin
          next_r.lret.valid = 1'b1;
          if (r.op == SPF_OP_SIG)
            next_r.lret.data = INSTR.zptr[0] ? SIG_BYTE1 : SIG_BYTE0;
          else
            next_r.lret.data = INSTR.zptr[1] ? FUSE_HIGH :
                               (INSTR.zptr[0] ? r.lockb : FUSE_LOW);
          next_r.state = SPF_IDLE;
          {next_r.sig, next_r.reen, next_r.lock, next_r.pwr, next_r.pers, next_r.en} = 6'h00;
        end
        else if (r.win == 3'h1)
        begin
          // Window expired unused
          next_r.state = SPF_IDLE;
          {next_r.sig, next_r.reen, next_r.lock, next_r.pwr, next_r.pers, next_r.en} = 6'h00;
        end
        else
          next_r.win = r.win - 3'h1;
      end
      SPF_PROG:
      begin
        // Register writes only update the interrupt enable here, so no re-enable
        if (csr_wr)
          next_r.ie = REG_WDATA[`SPF_BIT_RDY_IE];
        next_r.prog_cnt = r.prog_cnt - 32'h0000_0001;
        if (page_busy_done)
        begin
          if (r.pwr)
            next_r.buf_vld = '0;
          {next_r.pwr, next_r.pers, next_r.en} = 3'b000;
          next_r.halt = 1'b0;
          next_r.state = SPF_IDLE;
        end
      end
      default: next_r.state = SPF_IDLE;
    endcase
    next_r.irq = next_r.ie && GLOBAL_IE && !next_r.en;
  end

  // Buffer data, write-once per word until cleared
  genvar gi;
  generate
    for (gi = 0; gi < `SPF_BUF_DEPTH; gi++)
    begin : g_buf
      always_ff @(posedge CORE_CLK)
      begin
        if (r.state == SPF_ARMED && INSTR.store && r.op == SPF_OP_FILL
            && zword == 6'(gi) && !r.buf_vld[gi])
          buf_mem[gi] <= INSTR.rdata;
      end
    end
  endgenerate

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      r <= '0;
      r.state <= SPF_IDLE;
      r.op <= SPF_OP_NONE;
      r.lockb <= 8'hFF;
      r.rvec <= `SPF_APP_RESET;
    end
    else
      r <= next_r;
  end

  assign REG_RDATA = r.rdata;
  assign LOAD_RET = r.lret;
  assign READY_IRQ = r.irq;
  assign CORE_HALT = r.halt;
  assign SECTION_BLOCKED = r.busy;
  assign RESET_VECTOR = r.rvec;
  assign LOCK_BITS = r.lockb;

  busy_on_rww_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (r.state == SPF_ARMED && INSTR.store && (r.op == SPF_OP_PWR || r.op == SPF_OP_PERS)
     && INSTR.zptr[15:`SPF_PAGE_LSB] < RWW_PAGE_LIMIT) |=> SECTION_BLOCKED)
    else $error("busy flag not set");
  irq_level_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (r.ie && GLOBAL_IE && !r.en && $stable(GLOBAL_IE)) |-> READY_IRQ)
    else $error("ready interrupt missing");
  window_expire_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (r.state == SPF_ARMED && r.win == 3'h1 && !INSTR.store && !INSTR.load)
    |=> r.state == SPF_IDLE && !r.en)
    else $error("window did not expire");
  bad_cmd_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (r.state == SPF_IDLE && csr_wr && cmd != `SPF_CMD_FILL && cmd != `SPF_CMD_PERS
     && cmd != `SPF_CMD_PWR && cmd != `SPF_CMD_LOCK && cmd != `SPF_CMD_REEN
     && cmd != `SPF_CMD_SIG) |=> r.state == SPF_IDLE)
    else $error("illegal command accepted");
  sig_store_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (r.state == SPF_ARMED && r.op == SPF_OP_SIG && INSTR.store)
    |=> $stable(r.lockb) && $stable(r.buf_vld))
    else $error("signature store changed state");
  prog_hold_en_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (r.state == SPF_PROG && !page_busy_done) |=> r.en)
    else $error("enable dropped mid program");
  fill_clear_busy_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (r.state == SPF_ARMED && r.op == SPF_OP_FILL && INSTR.store) |=> !SECTION_BLOCKED)
    else $error("fill did not clear busy");
  halt_no_concurrent_read_region_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (r.state == SPF_PROG && !r.tgt_rww && !page_busy_done) |-> CORE_HALT)
    else $error("core not halted");

  // Shared terms for the checks; prog_start marks an erase or write launch
  logic        arm_store;
  logic        arm_load;
  logic        prog_start;
  logic [8:0]  z_page;
  assign arm_store = (r.state == SPF_ARMED) && INSTR.store;
  assign arm_load = (r.state == SPF_ARMED) && INSTR.load && !INSTR.store;
  assign prog_start = arm_store && (r.op == SPF_OP_PWR || r.op == SPF_OP_PERS);
  assign z_page = INSTR.zptr[15:`SPF_PAGE_LSB];
  app_vector_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    ($rose(r.rvec_set) && $past(r.fuse_q2)) |-> RESET_VECTOR == `SPF_APP_RESET)
    else $error("application vector wrong");
  boot_vector_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    ($rose(r.rvec_set) && !$past(r.fuse_q2)) |-> RESET_VECTOR == BOOT_RESET_ADDR)
    else $error("boot vector wrong");
  vector_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (r.rvec_set && $past(r.rvec_set)) |-> $stable(RESET_VECTOR))
    else $error("reset vector changed");
  irq_en_block_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    r.en |-> !READY_IRQ)
    else $error("interrupt while enable set");
  busy_read_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (REG_RD && REG_ADDR == `SPF_CSR_ADDR)
    |=> REG_RDATA[`SPF_BIT_BUSY] == $past(SECTION_BLOCKED))
    else $error("busy flag misread");
  reen_unblock_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (arm_store && r.op == SPF_OP_REEN) |=> !SECTION_BLOCKED)
    else $error("re-enable left section blocked");
  reen_discard_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (arm_store && r.op == SPF_OP_REEN) |=> r.buf_vld == '0)
    else $error("re-enable kept buffer");
  prog_busy_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (r.state == SPF_PROG) |=> $stable(SECTION_BLOCKED))
    else $error("busy changed mid program");
  sig_load_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (arm_load && r.op == SPF_OP_SIG && r.win > 3'h1)
    |=> LOAD_RET.valid && LOAD_RET.data == ($past(INSTR.zptr[0]) ? SIG_BYTE1 : SIG_BYTE0))
    else $error("signature byte wrong");
  load_late_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (arm_load && r.win == 3'h1) |=> !LOAD_RET.valid)
    else $error("late load answered");
  sig_store_busy_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (arm_store && r.op == SPF_OP_SIG)
    |=> $stable(SECTION_BLOCKED) && r.state == SPF_IDLE)
    else $error("signature store acted");
  lock_prog_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (arm_store && r.op == SPF_OP_LOCK)
    |=> LOCK_BITS == ($past(LOCK_BITS) & ($past(INSTR.rdata[7:0]) | 8'hC3)))
    else $error("lock bits wrong");
  lock_only_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !(arm_store && r.op == SPF_OP_LOCK) |=> $stable(LOCK_BITS))
    else $error("lock bits changed");
  lock_read_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (arm_load && r.op == SPF_OP_LOCK && r.win > 3'h1 && INSTR.zptr[1:0] == 2'b01)
    |=> LOAD_RET.data == LOCK_BITS)
    else $error("lock read wrong");
  fuse_low_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (arm_load && r.op == SPF_OP_LOCK && r.win > 3'h1 && INSTR.zptr[1:0] == 2'b00)
    |=> LOAD_RET.data == $past(FUSE_LOW))
    else $error("low fuse read wrong");
  fuse_high_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (arm_load && r.op == SPF_OP_LOCK && r.win > 3'h1 && INSTR.zptr[1:0] == 2'b11)
    |=> LOAD_RET.data == $past(FUSE_HIGH))
    else $error("high fuse read wrong");
  write_start_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (prog_start && r.op == SPF_OP_PWR) |=> r.pwr && r.en && r.state == SPF_PROG)
    else $error("page write not started");
  erase_start_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (prog_start && r.op == SPF_OP_PERS) |=> r.pers && !r.pwr && r.en)
    else $error("page erase not started");
  erase_keep_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (r.state == SPF_PROG && page_busy_done && r.pers) |=> $stable(r.buf_vld))
    else $error("erase touched buffer");
  write_clear_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (r.state == SPF_PROG && page_busy_done && r.pwr) |=> r.buf_vld == '0)
    else $error("buffer kept after write");
  fill_mark_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (arm_store && r.op == SPF_OP_FILL) |=> r.buf_vld[$past(zword)])
    else $error("buffer word not marked");
  fill_data_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (arm_store && r.op == SPF_OP_FILL && !r.buf_vld[zword])
    |=> buf_mem[$past(zword)] == $past(INSTR.rdata))
    else $error("buffer word data wrong");
  store_ends_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (arm_store && !prog_start) |=> r.state == SPF_IDLE && !r.en)
    else $error("store did not close window");
  arm_window_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (r.state == SPF_IDLE && csr_wr && cmd == `SPF_CMD_FILL)
    |=> r.state == SPF_ARMED && r.win == `SPF_STORE_WIN && r.en)
    else $error("window not opened");
  prog_end_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (r.state == SPF_PROG && page_busy_done)
    |=> r.state == SPF_IDLE && !r.en && !r.pwr && !r.pers && !CORE_HALT)
    else $error("program end not clean");
  page_latch_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    prog_start |=> r.page == $past(z_page))
    else $error("page not latched");
  rww_no_halt_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (prog_start && z_page < RWW_PAGE_LIMIT) |=> !CORE_HALT)
    else $error("core halted needlessly");
  no_concurrent_read_region_launch_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (prog_start && z_page >= RWW_PAGE_LIMIT) |=> CORE_HALT && $stable(SECTION_BLOCKED))
    else $error("protected launch wrong");
  op_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (r.state != SPF_IDLE) |=> $stable(r.op))
    else $error("command changed while busy");

endmodule // spf_ctrl

// ===== tb/spf_core_model.sv
`timescale 1ns/1ps
// Core side: one store or load pulse per call, issued just after an edge
module spf_core_model
  import spf_pkg::*;
(
  // Clock
  input  wire logic CORE_CLK,
  // Instruction strobes toward the controller
  output spf_instr_s INSTR
);
  initial INSTR = '0;
  task automatic issue(input logic st, input logic [15:0] z, input logic [15:0] r);
    INSTR.store <= st;
    INSTR.load  <= ~st;
    INSTR.zptr  <= z;
    INSTR.rdata <= r;
    @(posedge CORE_CLK);
    INSTR.store <= 1'b0;
    INSTR.load  <= 1'b0;
    // Pointer inverted at once, so stale values never look valid
    INSTR.zptr  <= ~z;
    INSTR.rdata <= ~r;
  endtask
endmodule // spf_core_model

// ===== tb/spf_ctrl_tb.sv
`timescale 1ns/1ps
`include "spf_cfg.svh"
`define CHK(n, e, g) chk(n, 16'(e), 16'(g))
module spf_ctrl_tb;
  import spf_pkg::*;
  // Short program time keeps the run brief
  localparam int          PROG = 8;
  localparam logic [15:0] BOOTA = 16'hE000;
  localparam logic [7:0]  SIG0 = 8'h3C;
  localparam logic [7:0]  SIG1 = 8'hC3;
  logic        clk = 0, rst_n = 0, wr_s = 0, rd_s = 0, gie = 0, bfuse = 1;
  logic [3:0]  addr = '0;
  logic [7:0]  wd = '0, rdat, flo = '0, fhi = '0, lockb, lock_m = 8'hFF;
  logic        irq, halt, blocked;
  logic [15:0] vec, z, r;
  spf_instr_s  instr;
  spf_lret_s   lret;
  int          err_total = 0, check_count = 0;
  logic [5:0]  bad [6] = '{6'h07, 6'h13, 6'h23, 6'h00, 6'h3F, 6'h31};

  always #5 clk = ~clk;

  spf_core_model core (.CORE_CLK(clk), .INSTR(instr));
  spf_ctrl #(.BOOT_RESET_ADDR(BOOTA), .SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .PROG_CYC(PROG))
    spf_ctrl_inst (.CORE_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wd),
    .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdat), .INSTR(instr), .GLOBAL_IE(gie),
    .LOAD_RET(lret), .READY_IRQ(irq), .CORE_HALT(halt), .SECTION_BLOCKED(blocked),
    .BOOT_RESET_FUSE(bfuse), .FUSE_LOW(flo), .FUSE_HIGH(fhi), .RESET_VECTOR(vec),
    .LOCK_BITS(lockb));

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("FAIL %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask

  task automatic wr(input logic [7:0] d);
    addr <= `SPF_CSR_ADDR;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input string n, input logic [7:0] e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    `CHK(n, e, rdat);
    @(posedge clk);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (6000) @(posedge clk);
    err_total++;
    give_verdict();
  end

  initial
  begin
    r = 16'($urandom(32'hc99d505d));
    flo <= 8'($urandom);
    fhi <= 8'($urandom);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`SPF_CSR_ADDR, "csr reset", 8'h00);
    rd(4'h5, "unmapped", 8'h00);
    `CHK("vector app", 16'h0000, vec);
    $display("reset test done");
    for (int b = 0; b < 2; b++)
    begin
      wr(8'h21);
      core.issue(1'b0, 16'(b), 16'($urandom));
      #1;
      `CHK("sig valid", 1, lret.valid);
      `CHK("sig byte", b ? SIG1 : SIG0, lret.data);
      @(posedge clk);
    end
    wr(8'h21);
    core.issue(1'b1, 16'($urandom), 16'($urandom));
    repeat (5) @(posedge clk);
    rd(`SPF_CSR_ADDR, "sig store", 8'h00);
    `CHK("sig store lock", lock_m, lockb);
    $display("signature test done");
    r = 16'($urandom);
    wr(8'h09);
    core.issue(1'b1, 16'($urandom), r);
    lock_m &= r[7:0] | 8'hC3;
    repeat (2) @(posedge clk);
    `CHK("lock prog", lock_m, lockb);
    rd(`SPF_CSR_ADDR, "lock clear", 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h09);
      core.issue(1'b0, i == 0 ? 16'h0001 : i == 1 ? 16'h0000 : 16'h0003, 16'h0000);
      #1;
      `CHK("lock read", i == 0 ? lock_m : i == 1 ? flo : fhi, lret.data);
      @(posedge clk);
    end
    $display("lock test done");
    z = {1'b0, 8'($urandom), 7'($urandom)};
    wr(8'h03);
    core.issue(1'b1, z, 16'($urandom));
    rd(`SPF_CSR_ADDR, "erase busy", 8'h43);
    `CHK("blocked", 1, blocked);
    `CHK("no halt", 0, halt);
    wr(8'h11);
    core.issue(1'b1, 16'($urandom), 16'($urandom));
    repeat (PROG) @(posedge clk);
    rd(`SPF_CSR_ADDR, "reen refused", 8'h40);
    wr(8'h01);
    repeat (4) @(posedge clk);
    core.issue(1'b1, 16'($urandom), 16'($urandom));
    rd(`SPF_CSR_ADDR, "late store", 8'h40);
    wr(8'h01);
    repeat (3) @(posedge clk);
    core.issue(1'b1, 16'($urandom), 16'($urandom));
    rd(`SPF_CSR_ADDR, "fill clears", 8'h00);
    `CHK("unblocked", 0, blocked);
    wr(8'h03);
    core.issue(1'b1, z, 16'($urandom));
    repeat (PROG + 2) @(posedge clk);
    wr(8'h11);
    core.issue(1'b1, 16'($urandom), 16'($urandom));
    rd(`SPF_CSR_ADDR, "reen", 8'h00);
    $display("erase test done");
    wr(8'h05);
    core.issue(1'b1, {1'b1, 8'($urandom), 7'($urandom)}, 16'($urandom));
    #1;
    `CHK("halt", 1, halt);
    @(posedge clk);
    rd(`SPF_CSR_ADDR, "write run", 8'h05);
    repeat (PROG) @(posedge clk);
    `CHK("halt end", 0, halt);
    rd(`SPF_CSR_ADDR, "write done", 8'h00);
    $display("write test done");
    foreach (bad[i])
    begin
      wr({2'b00, bad[i]});
      rd(`SPF_CSR_ADDR, "bad cmd", 8'h00);
    end
    $display("command test done");
    gie <= 1'b1;
    wr(8'h81);
    #1;
    `CHK("irq armed", 0, irq);
    repeat (7) @(posedge clk);
    rd(`SPF_CSR_ADDR, "ie kept", 8'h80);
    `CHK("irq on", 1, irq);
    gie <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("irq off", 0, irq);
    `CHK("vector kept", 16'h0000, vec);
    $display("interrupt test done");
    @(posedge clk);
    bfuse <= 1'b0;
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    `CHK("vector boot", BOOTA, vec);
    $display("boot test done");
    give_verdict();
  end
endmodule // spf_ctrl_tb
